// File: rtl/arxcdr_pkg.sv
package arxcdr_pkg;
    // samples per bit and voting positions, normal and double speed
    localparam logic [4:0] ARXCDR_SPB_NORMAL = 5'h10;
    localparam logic [4:0] ARXCDR_SPB_DOUBLE = 5'h08;
    localparam logic [4:0] ARXCDR_VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] ARXCDR_VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [3:0] ARXCDR_BITS_MIN = 4'h5;
    localparam logic [3:0] ARXCDR_BITS_MAX = 4'hA;
    localparam int ARXCDR_DATA_W = 10;
    localparam logic [4:0] ARXCDR_SAMPLE_ONE = 5'h01;

    typedef enum logic [1:0] {
        ARXCDR_IDLE = 2'b00,
        ARXCDR_START = 2'b01,
        ARXCDR_DATA = 2'b10,
        ARXCDR_GUARD = 2'b11
    } arxcdr_state_t;

    typedef struct packed {
        logic [ARXCDR_DATA_W-1:0] data;
        logic stop_bit_error_flag;
    } arxcdr_frame_t;
endpackage

// File: rtl/arxcdr_sync.sv
`timescale 1ns/1ps
module arxcdr_sync
    import arxcdr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // arxcdr_sync

// File: rtl/arxcdr_rx.sv
`timescale 1ns/1ps
module arxcdr_rx
    import arxcdr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_tick,
    input wire logic double_speed_select,
    input wire logic [3:0] frame_bits,
    input wire logic serial_in,
    output arxcdr_frame_t frame_out,
    output logic frame_valid,
    output logic busy
);
    logic line;
    arxcdr_state_t state;
    logic [4:0] sample_no;
    logic [3:0] bit_no;
    logic [3:0] frame_len;
    logic prev_line;
    logic vote_a;
    logic vote_b;
    logic [ARXCDR_DATA_W-1:0] shift;
    logic [4:0] spb;
    logic [4:0] vfirst;
    logic voted;
    logic at_vote_end;
    logic at_bit_end;
    logic data_vote;
    logic stop_vote;
    logic last_bit;

    // the stop bit sits one position above the last data bit
    function automatic logic is_stop(input logic [3:0] idx, input logic [3:0] len);
        return idx == len;
    endfunction

    function automatic logic majority(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    arxcdr_sync u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(serial_in),
        .sync_out(line)
    );

    assign spb = double_speed_select ? ARXCDR_SPB_DOUBLE : ARXCDR_SPB_NORMAL;
    assign vfirst = double_speed_select ? ARXCDR_VOTE_FIRST_DOUBLE
                                        : ARXCDR_VOTE_FIRST_NORMAL;
    assign voted = majority(vote_a, vote_b, line);
    assign at_vote_end = sample_no == vfirst + 5'h02;
    assign at_bit_end = sample_no == spb;
    assign busy = state != ARXCDR_IDLE;
    assign last_bit = is_stop(bit_no, frame_len);
    // one decode of the vote instants, shared by the shifter and the output stage
    assign data_vote = sample_tick && state == ARXCDR_DATA && at_vote_end && !last_bit;
    assign stop_vote = sample_tick && state == ARXCDR_DATA && at_vote_end && last_bit;

    // samples of the current bit used in the vote
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vote_a <= 1'b1;
            vote_b <= 1'b1;
        end else if (sample_tick) begin
            if (sample_no == vfirst) begin
                vote_a <= line;
            end
            if (sample_no == vfirst + 5'h01) begin
                vote_b <= line;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_line <= 1'b1;
        end else if (sample_tick) begin
            prev_line <= line;
        end
    end

    // clamp unsupported lengths into the legal range
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_len <= ARXCDR_BITS_MIN;
        end else if (state == ARXCDR_IDLE) begin
            if (frame_bits < ARXCDR_BITS_MIN) begin
                frame_len <= ARXCDR_BITS_MIN;
            end else if (frame_bits > ARXCDR_BITS_MAX) begin
                frame_len <= ARXCDR_BITS_MAX;
            end else begin
                frame_len <= frame_bits;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ARXCDR_IDLE;
            sample_no <= 5'h00;
            bit_no <= 4'h0;
        end else if (sample_tick) begin
            unique case (state)
                ARXCDR_IDLE: begin
                    if (prev_line && !line) begin
                        state <= ARXCDR_START;
                        sample_no <= ARXCDR_SAMPLE_ONE + 5'h01;
                    end
                end
                ARXCDR_START: begin
                    if (at_vote_end && voted) begin
                        state <= ARXCDR_IDLE;
                        sample_no <= 5'h00;
                    end else if (at_bit_end) begin
                        state <= ARXCDR_DATA;
                        sample_no <= ARXCDR_SAMPLE_ONE;
                        bit_no <= 4'h0;
                    end else begin
                        sample_no <= sample_no + 5'h01;
                    end
                end
                ARXCDR_DATA: begin
                    if (at_vote_end && last_bit) begin
                        // stop bit voted: later stop bits are ignored
                        state <= double_speed_select ? ARXCDR_GUARD : ARXCDR_IDLE;
                        sample_no <= 5'h00;
                    end else if (at_bit_end) begin
                        sample_no <= ARXCDR_SAMPLE_ONE;
                        bit_no <= bit_no + 4'h1;
                    end else begin
                        sample_no <= sample_no + 5'h01;
                    end
                end
                ARXCDR_GUARD: begin
                    state <= ARXCDR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift <= '0;
        end else if (data_vote) begin
            shift[bit_no] <= voted;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_out <= '0;
            frame_valid <= 1'b0;
        end else begin
            frame_valid <= 1'b0;
            if (stop_vote) begin
                frame_out.data <= shift;
                frame_out.stop_bit_error_flag <= !voted;
                frame_valid <= 1'b1;
            end
        end
    end
endmodule // arxcdr_rx

// File: bench/arxcdr_rx_assertions.sv
`timescale 1ns/1ps
module arxcdr_rx_assertions
    import arxcdr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_tick,
    input wire logic double_speed_select,
    input wire logic [3:0] frame_bits,
    input wire logic serial_in,
    input arxcdr_frame_t frame_out,
    input wire logic frame_valid,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int tcnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tcnt <= 0;
        end else begin
            tcnt <= !busy ? 0 : tcnt + int'(sample_tick);
        end
    end
    a_pulse_once: assert property (frame_valid |=> !frame_valid) else $error("pulse");
    a_valid_tick: assert property (frame_valid |-> $past(sample_tick)) else $error("tick");
    a_out_held: assert property ($changed(frame_out) |-> frame_valid) else $error("out");
    a_start_tick: assert property ($rose(busy) |-> $past(sample_tick)) else $error("start");
    a_start_low: assert property ($rose(busy) |-> !$past(serial_in, 3))
        else $error("low");
    a_busy_bound: assert property (busy |-> tcnt <= 186) else $error("long");
    a_frame_len: assert property (frame_valid |-> tcnt == (double_speed_select ? 8 : 16)
        * (frame_bits + 1) + (double_speed_select ? 5 : 9)) else $error("length");
    a_rearm_fast: assert property (frame_valid && !double_speed_select |-> !busy)
        else $error("busy");
    c_bad_stop: cover property (frame_valid && frame_out.stop_bit_error_flag);
    c_double: cover property (frame_valid && double_speed_select);
    c_noise: cover property ($fell(busy) && !frame_valid);
endmodule // arxcdr_rx_assertions
bind arxcdr_rx arxcdr_rx_assertions chk (.*);

// File: bench/arxcdr_tx_model.sv
`timescale 1ns/1ps
module arxcdr_tx_model (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    task automatic send(input logic [9:0] d, input int n, input logic stp, input int cpb);
        for (int i = -1; i <= n; i++) begin
            line = i < 0 ? 1'b0 : i == n ? stp : d[i];
            repeat (cpb) @(negedge clk);
        end
        // a low stop bit needs idle after it, else the next start has no edge
        line = 1'b1;
        repeat (stp ? 0 : cpb) @(negedge clk);
    endtask
endmodule // arxcdr_tx_model

// File: bench/async_rx_clock_data_recovery_bench.sv
`timescale 1ns/1ps
module async_rx_clock_data_recovery_bench;
    import arxcdr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sample_tick = 1'b0, double_speed_select = 1'b0;
    logic [3:0] frame_bits = 4'h5;
    logic serial_in, frame_valid, busy;
    arxcdr_frame_t frame_out;
    logic [21:0] e, q[$];
    logic [10:0] d;
    int fails = 0, n_tests = 0, seed = 86531;
    always #2 clk = ~clk;
    always @(negedge clk) sample_tick <= ~sample_tick;
    arxcdr_rx dut (.*);
    arxcdr_tx_model tx (.clk(clk), .line(serial_in));
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("%0d checks, %0d bad", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // an unexpected frame gets a note that can never match
    // look on the falling edge, half a cycle after the registered pulse settles
    always @(negedge clk) if (frame_valid === 1'b1) begin
        e = q.size() ? q.pop_front() : 22'h000001;
        chk(frame_out & e[21:11], e[10:0]);
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        tx.send(10'h000, 0, 1'b1, 6);
        repeat (40) @(negedge clk);
        chk({10'h000, busy}, 11'h000);
        $display("noise done");
        for (int m = 0; m < 2; m++) begin
            double_speed_select = m[0];
            // frames back to back, so each start bit realigns
            for (int n = 5; n <= 10; n++) begin
                frame_bits = n[3:0];
                d = 11'($random(seed));
                e[21:12] = 10'h3FF >> (10 - n);
                q.push_back({e[21:12], 1'b1, d[9:0] & e[21:12], ~d[10]});
                tx.send(d[9:0], n, d[10], m ? 16 : 32 + n % 2);
            end
            $display("mode %0d done", m);
        end
        chk(11'(q.size()), 11'h000);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule // async_rx_clock_data_recovery_bench
